// [ehc_defs.vh]
// Constants for the byte-wide EEPROM host controller
`ifndef EHC_DEFS_VH
`define EHC_DEFS_VH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define EHC_CLK_NS 10
`define EHC_WE_LOW_NS 50
`define EHC_READ_ACC_NS 120
`define EHC_LOAD_WIN_US 150
`define EHC_PROG_MS 10

// ****************************************************************
// Command codes on the user port
// ****************************************************************
`define EHC_OP_READ 2'h0
`define EHC_OP_WRITE 2'h1
`define EHC_OP_LOCK 2'h2
`define EHC_OP_UNLOCK 2'h3

// ****************************************************************
// Pin widths and page layout
// ****************************************************************
`define EHC_ADDR_W 15
`define EHC_DATA_W 8
`define EHC_PAGE_LSB 6
`define EHC_POLL_BIT 7
`define EHC_TOGGLE_BIT 6

// ****************************************************************
// Lock command sequences (addresses shared, only the third data byte differs)
// ****************************************************************
`define EHC_SEQ_ADDR0 15'h0AAA
`define EHC_SEQ_ADDR1 15'h0555
`define EHC_SEQ_ADDR2 15'h0AAA
`define EHC_LOCK_D0 8'h3C
`define EHC_LOCK_D1 8'hC3
`define EHC_LOCK_D2 8'h5A
`define EHC_UNLOCK_D0 8'h3C
`define EHC_UNLOCK_D1 8'hC3
`define EHC_UNLOCK_D2 8'hA5

`endif

// [ehc_timer.v]
// Down-counting interval timer with a sticky expiry flag
`timescale 1ns/1ps
`default_nettype none

module ehc_timer #(
  parameter W = 20
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Control
  input wire load,
  input wire [W-1:0] value,
  // Status
  output reg expired
);

  reg [W-1:0] count_reg;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= {W{1'b0}};
      expired <= 1'b0;
    end else if (load) begin
      count_reg <= value;
      expired <= (value == {W{1'b0}});
    end else if (count_reg != {W{1'b0}}) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
      expired <= (count_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule

`default_nettype wire

// [ehc_host.v]
// Host-side controller driving a byte-wide EEPROM through its pins
`timescale 1ns/1ps
`default_nettype none
`include "ehc_defs.vh"

module ehc_host #(
  parameter LOAD_CYC = `EHC_LOAD_WIN_US * 1000 / `EHC_CLK_NS,
  parameter PROG_CYC = `EHC_PROG_MS * 1000000 / `EHC_CLK_NS,
  parameter [14:0] SEQ_ADDR0 = `EHC_SEQ_ADDR0,
  parameter [14:0] SEQ_ADDR1 = `EHC_SEQ_ADDR1,
  parameter [14:0] SEQ_ADDR2 = `EHC_SEQ_ADDR2,
  parameter [7:0] LOCK_D0 = `EHC_LOCK_D0,
  parameter [7:0] LOCK_D1 = `EHC_LOCK_D1,
  parameter [7:0] LOCK_D2 = `EHC_LOCK_D2,
  parameter [7:0] UNLOCK_D0 = `EHC_UNLOCK_D0,
  parameter [7:0] UNLOCK_D1 = `EHC_UNLOCK_D1,
  parameter [7:0] UNLOCK_D2 = `EHC_UNLOCK_D2
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // User command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [14:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire cmd_id,
  input wire cmd_last,
  output reg cmd_ready,
  // User answers
  output reg rd_valid,
  output reg [7:0] rd_data,
  output reg done,
  output reg timeout,
  output reg busy,
  output reg soft_write_lock,
  // Memory pins
  output reg [14:0] byte_address_lines,
  output reg [7:0] mem_dout,
  output reg mem_doe,
  input wire [7:0] mem_din,
  output reg mem_ce_n,
  output reg mem_oe_n,
  output reg mem_we_n,
  output reg id_area_select_line
);

  // ****************************************************************
  // Derived cycle counts
  // ****************************************************************
  localparam [31:0] WE_W =
    (`EHC_WE_LOW_NS + `EHC_CLK_NS - 1) / `EHC_CLK_NS;
  localparam [31:0] RD_W =
    (`EHC_READ_ACC_NS + `EHC_CLK_NS - 1) / `EHC_CLK_NS + 1;
  localparam [7:0] WE_CYC = WE_W[7:0];
  localparam [7:0] RD_CYC = RD_W[7:0];
  localparam [31:0] LOAD_W = LOAD_CYC;
  localparam [31:0] PROG_W = PROG_CYC;
  // Margin covers strobe release to timer load and take to next strobe
  localparam [19:0] LOAD_CNT = LOAD_W[19:0] - 20'h00008;
  localparam [19:0] PROG_CNT = PROG_W[19:0];

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_WR = 6'h02;
  localparam [5:0] S_NEXT = 6'h04;
  localparam [5:0] S_LOAD = 6'h08;
  localparam [5:0] S_RD = 6'h10;
  localparam [5:0] S_POLL = 6'h20;

  // ****************************************************************
  // State
  // ****************************************************************
  reg [5:0] state_reg;
  reg [7:0] step_reg;
  reg [1:0] seq_idx_reg;
  reg seq_on_reg;
  reg seq_only_reg;
  reg seq_unlock_reg;
  reg poll_rd_reg;
  reg have_prev_reg;
  reg prev6_reg;
  reg [14:0] cur_addr_reg;
  reg [7:0] cur_data_reg;
  reg cur_id_reg;
  reg cur_last_reg;
  reg [14:0] poll_addr_reg;
  reg [8:0] page_reg;
  reg pend_reg;
  reg [1:0] pend_op_reg;
  reg [14:0] pend_addr_reg;
  reg [7:0] pend_data_reg;
  reg pend_id_reg;
  reg pend_last_reg;
  reg tmr_load_reg;
  reg [19:0] tmr_val_reg;
  wire tmr_expired;

  ehc_timer #(.W(20)) u_timer (
    .clock(clock),
    .rst(rst),
    .load(tmr_load_reg),
    .value(tmr_val_reg),
    .expired(tmr_expired)
  );

  // A command held over from a page load runs before any new one
  wire take = cmd_valid & cmd_ready;
  wire go = pend_reg | take;
  wire [1:0] s_op = pend_reg ? pend_op_reg : cmd_op;
  wire [14:0] s_addr = pend_reg ? pend_addr_reg : cmd_addr;
  wire [7:0] s_data = pend_reg ? pend_data_reg : cmd_data;
  wire s_id = pend_reg ? pend_id_reg : cmd_id;
  wire s_last = pend_reg ? pend_last_reg : cmd_last;
  wire same_page = (cmd_op == `EHC_OP_WRITE) && (cmd_id == cur_id_reg) &&
    (cmd_addr[14:`EHC_PAGE_LSB] == page_reg);

  function [14:0] seq_addr;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: seq_addr = SEQ_ADDR0;
        2'h1: seq_addr = SEQ_ADDR1;
        default: seq_addr = SEQ_ADDR2;
      endcase
    end
  endfunction

  function [7:0] seq_data;
    input unlock;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: seq_data = unlock ? UNLOCK_D0 : LOCK_D0;
        2'h1: seq_data = unlock ? UNLOCK_D1 : LOCK_D1;
        default: seq_data = unlock ? UNLOCK_D2 : LOCK_D2;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin strobe launchers
  // ****************************************************************
  // Output enable stays high for every write so no write is inhibited
  task start_wr;
    input [14:0] a;
    input [7:0] d;
    begin
      byte_address_lines <= a;
      mem_dout <= d;
      mem_doe <= 1'b1;
      mem_ce_n <= 1'b0;
      mem_oe_n <= 1'b1;
      step_reg <= 8'h00;
      state_reg <= S_WR;
    end
  endtask

  task start_rd;
    input [14:0] a;
    begin
      byte_address_lines <= a;
      mem_doe <= 1'b0;
      mem_ce_n <= 1'b0;
      mem_oe_n <= 1'b0;
      step_reg <= 8'h00;
      state_reg <= S_RD;
    end
  endtask

  task start_poll;
    begin
      tmr_load_reg <= 1'b1;
      tmr_val_reg <= PROG_CNT;
      have_prev_reg <= 1'b0;
      cmd_ready <= 1'b0;
      state_reg <= S_POLL;
    end
  endtask

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      step_reg <= 8'h00;
      seq_idx_reg <= 2'h0;
      seq_on_reg <= 1'b0;
      seq_only_reg <= 1'b0;
      seq_unlock_reg <= 1'b0;
      poll_rd_reg <= 1'b0;
      have_prev_reg <= 1'b0;
      prev6_reg <= 1'b0;
      cur_addr_reg <= 15'h0000;
      cur_data_reg <= 8'h00;
      cur_id_reg <= 1'b0;
      cur_last_reg <= 1'b0;
      poll_addr_reg <= 15'h0000;
      page_reg <= 9'h000;
      pend_reg <= 1'b0;
      pend_op_reg <= 2'h0;
      pend_addr_reg <= 15'h0000;
      pend_data_reg <= 8'h00;
      pend_id_reg <= 1'b0;
      pend_last_reg <= 1'b0;
      tmr_load_reg <= 1'b0;
      tmr_val_reg <= 20'h00000;
      cmd_ready <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      timeout <= 1'b0;
      busy <= 1'b0;
      soft_write_lock <= 1'b0;
      byte_address_lines <= 15'h0000;
      mem_dout <= 8'h00;
      mem_doe <= 1'b0;
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      id_area_select_line <= 1'b0;
    end else begin
      tmr_load_reg <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      timeout <= 1'b0;
      busy <= (state_reg != S_IDLE) || go;
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            pend_reg <= 1'b0;
            cmd_ready <= 1'b0;
            cur_addr_reg <= s_addr;
            cur_data_reg <= s_data;
            cur_id_reg <= s_id;
            cur_last_reg <= s_last;
            seq_idx_reg <= 2'h0;
            seq_unlock_reg <= (s_op == `EHC_OP_UNLOCK);
            seq_only_reg <= s_op[1];
            poll_rd_reg <= 1'b0;
            if (s_op == `EHC_OP_READ) begin
              id_area_select_line <= s_id;
              start_rd(s_addr);
            end else if (s_op[1] || soft_write_lock) begin
              // Sequence bytes always go to the main array
              seq_on_reg <= 1'b1;
              id_area_select_line <= 1'b0;
              start_wr(seq_addr(2'h0), seq_data(s_op[0] & s_op[1], 2'h0));
            end else begin
              seq_on_reg <= 1'b0;
              id_area_select_line <= s_id;
              start_wr(s_addr, s_data);
            end
          end
        end
        S_WR: begin
          // Low time of the write strobe clears the glitch filter
          step_reg <= step_reg + 8'h01;
          if (step_reg == 8'h00) begin
            mem_we_n <= 1'b0;
          end
          if (step_reg == WE_CYC) begin
            mem_we_n <= 1'b1;
          end
          if (step_reg == WE_CYC + 8'h01) begin
            mem_ce_n <= 1'b1;
            mem_doe <= 1'b0;
            state_reg <= S_NEXT;
          end
        end
        S_NEXT: begin
          // One idle cycle with chip enable high between strobes
          if (seq_on_reg && seq_idx_reg != 2'h2) begin
            seq_idx_reg <= seq_idx_reg + 2'h1;
            start_wr(seq_addr(seq_idx_reg + 2'h1),
              seq_data(seq_unlock_reg, seq_idx_reg + 2'h1));
          end else if (seq_on_reg && !seq_only_reg) begin
            seq_on_reg <= 1'b0;
            id_area_select_line <= cur_id_reg;
            start_wr(cur_addr_reg, cur_data_reg);
          end else if (seq_on_reg) begin
            poll_addr_reg <= SEQ_ADDR2;
            start_poll;
          end else begin
            poll_addr_reg <= cur_addr_reg;
            page_reg <= cur_addr_reg[14:`EHC_PAGE_LSB];
            if (cur_last_reg) begin
              start_poll;
            end else begin
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= LOAD_CNT;
              cmd_ready <= 1'b1;
              state_reg <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (take) begin
            cmd_ready <= 1'b0;
            if (same_page) begin
              cur_addr_reg <= cmd_addr;
              cur_data_reg <= cmd_data;
              cur_last_reg <= cmd_last;
              start_wr(cmd_addr, cmd_data);
            end else begin
              // Another page or command closes this load first
              pend_reg <= 1'b1;
              pend_op_reg <= cmd_op;
              pend_addr_reg <= cmd_addr;
              pend_data_reg <= cmd_data;
              pend_id_reg <= cmd_id;
              pend_last_reg <= cmd_last;
              start_poll;
            end
          end else if (tmr_expired && !tmr_load_reg) begin
            start_poll;
          end
        end
        S_POLL: begin
          poll_rd_reg <= 1'b1;
          start_rd(poll_addr_reg);
        end
        S_RD: begin
          step_reg <= step_reg + 8'h01;
          if (step_reg == RD_CYC) begin
            mem_oe_n <= 1'b1;
            mem_ce_n <= 1'b1;
            if (!poll_rd_reg) begin
              rd_data <= mem_din;
              rd_valid <= 1'b1;
              cmd_ready <= 1'b1;
              state_reg <= S_IDLE;
            end else if (have_prev_reg &&
                mem_din[`EHC_TOGGLE_BIT] == prev6_reg) begin
              // Toggle bit stood still: programming is over
              done <= 1'b1;
              if (seq_only_reg) begin
                soft_write_lock <= !seq_unlock_reg;
              end
              cmd_ready <= !pend_reg;
              state_reg <= S_IDLE;
            end else if (tmr_expired) begin
              timeout <= 1'b1;
              cmd_ready <= !pend_reg;
              state_reg <= S_IDLE;
            end else begin
              prev6_reg <= mem_din[`EHC_TOGGLE_BIT];
              have_prev_reg <= 1'b1;
              state_reg <= S_POLL;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [ehc_host_properties.sv]
// Pin protocol checks for the memory host controller
`timescale 1ns/1ps
`default_nettype none
module ehc_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Observed outputs
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic done,
  input wire logic timeout,
  input wire logic busy,
  input wire logic soft_write_lock,
  input wire logic [14:0] byte_address_lines,
  input wire logic [7:0] mem_dout,
  input wire logic mem_doe,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_we_low; !mem_we_n [*5] ##1 mem_we_n; endsequence
  sequence s_rd_low; (!mem_ce_n && mem_we_n && !mem_doe) [*8]; endsequence
  property p_we_width; $fell(mem_we_n) |-> s_we_low; endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");
  property p_we_ctl;
    !mem_we_n |-> !mem_ce_n && mem_oe_n && mem_doe;
  endproperty
  a_we_ctl: assert property (p_we_ctl)
    else $error("write strobe without select");
  property p_we_hold;
    !mem_we_n && !$fell(mem_we_n) |-> $stable(byte_address_lines)
      && $stable(mem_dout);
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("address or data moved under strobe");
  property p_no_clash; mem_doe |-> mem_oe_n; endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("host drives data while output enabled");
  property p_rd_hold; $fell(mem_oe_n) |-> s_rd_low; endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read access cut short");
  property p_rd_addr;
    !mem_oe_n && !$fell(mem_oe_n) |-> $stable(byte_address_lines);
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("address moved during read");
  property p_rd_valid;
    rd_valid |-> !$past(mem_oe_n, 2) ##1 !rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read answer without read access");
  property p_wr_busy; !mem_we_n |-> busy && !cmd_ready; endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("ready during write strobe");
  // A held command may keep ready low at completion, so check the strobes
  property p_done;
    done |-> mem_ce_n && mem_oe_n && !timeout ##1 !done;
  endproperty
  a_done: assert property (p_done)
    else $error("completion pulse wrong");
  property p_lock;
    $changed(soft_write_lock) |-> done || $past(done);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag moved without completion");
endmodule
bind ehc_host ehc_chk u_chk (
  .clock(clock), .rst(rst), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
  .done(done), .timeout(timeout), .busy(busy),
  .soft_write_lock(soft_write_lock),
  .byte_address_lines(byte_address_lines), .mem_dout(mem_dout),
  .mem_doe(mem_doe), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
  .mem_we_n(mem_we_n)
);
`default_nettype wire

// [ehc_mem_model.sv]
// Behavioural model of the byte-wide electrically erasable memory
`timescale 1ns/1ps
`default_nettype none
`include "ehc_defs.vh"
module ehc_mem_model (
  // Memory pins
  input wire logic [14:0] addr,
  input wire logic [7:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic id_sel,
  // Read drive toward the data lines
  output logic [7:0] q,
  output logic q_oe
);
  logic [7:0] mem [0:32767];
  logic [7:0] idm [0:63];
  logic [14:0] la [0:66];
  logic [7:0] ld [0:66];
  logic li [0:66];
  logic [14:0] a_cur;
  logic [7:0] last_d;
  logic id_cur, lock_nx;
  logic loading = 0, prog = 0, lock = 0, tgl = 0;
  realtime t_fall = 0, t_last = 0, t_prog = 0;
  // Load window scaled like the bench's host window of 40 cycles
  realtime load_ns = 400, prog_ns = 1500;
  int n = 0, n_prog = 0, skip;
  wire wr = !ce_n && !we_n && oe_n;
  wire rd = !ce_n && !oe_n && we_n;
  assign q_oe = rd;
  assign q = prog ? {~last_d[7], tgl, last_d[5:0]}
    : id_sel ? idm[addr[5:0]] : mem[addr];
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 64; i++) idm[i] = 8'hFF;
  end
  function automatic logic hit(input logic [7:0] d0, d1, d2);
    return n >= 3 && la[0] == `EHC_SEQ_ADDR0 && la[1] == `EHC_SEQ_ADDR1
      && la[2] == `EHC_SEQ_ADDR2 && ld[0] == d0 && ld[1] == d1 && ld[2] == d2;
  endfunction
  task automatic start_prog;
    loading = 0;
    prog = 1;
    t_prog = $realtime;
    n_prog = n_prog + 1;
    last_d = ld[n-1];
  endtask
  task automatic finish_prog;
    skip = 0;
    lock_nx = lock;
    if (hit(`EHC_LOCK_D0, `EHC_LOCK_D1, `EHC_LOCK_D2)) begin
      skip = 3;
      lock_nx = 1;
    end else if (hit(`EHC_UNLOCK_D0, `EHC_UNLOCK_D1, `EHC_UNLOCK_D2)) begin
      skip = 3;
      lock_nx = 0;
    end
    // Locked without the prefix: the timer runs but nothing is stored
    if (skip == 3 || !lock)
      for (int i = skip; i < n; i++)
        if (li[i]) idm[la[i][5:0]] = ld[i];
        else mem[la[i]] = ld[i];
    lock = lock_nx;
    n = 0;
    prog = 0;
  endtask
  always @(posedge wr) begin
    a_cur = addr;
    id_cur = id_sel;
    t_fall = $realtime;
  end
  always @(negedge wr) begin
    if ($realtime - t_fall >= 15 && !prog && n < 67) begin
      la[n] = a_cur;
      ld[n] = dq;
      li[n] = id_cur;
      n = n + 1;
      loading = 1;
      t_last = $realtime;
    end
  end
  // A read ends an open page load, as the poll would otherwise see array data
  always @(posedge rd) begin
    if (loading) start_prog();
    if (prog) tgl = !tgl;
  end
  always #5 begin
    if (loading && $realtime - t_last > load_ns) start_prog();
    if (prog && $realtime - t_prog >= prog_ns) finish_prog();
  end
endmodule
`default_nettype wire

// [ehc_tb.sv]
// Self-checking testbench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "ehc_defs.vh"
module tb;
  logic clock = 0;
  logic rst = 1;
  logic cmd_valid = 0, cmd_id = 0, cmd_last = 0;
  logic [1:0] cmd_op = 2'h0;
  logic [14:0] cmd_addr = 15'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rd_valid, done, timeout, busy, soft_write_lock;
  logic [14:0] byte_address_lines;
  logic [7:0] rd_data, mem_dout, mem_din, q, last_bus = 8'h00;
  logic mem_doe, mem_ce_n, mem_oe_n, mem_we_n, id_area_select_line, q_oe;
  logic dn, tm;
  int err_total = 0, n_checks = 0, cyc = 0, cy;
  // Undriven data lines change each cycle instead of keeping a stale byte
  assign mem_din = mem_doe ? mem_dout : q_oe ? q : ~last_bus;
  always @(posedge clock) last_bus <= mem_din;
  ehc_host #(.LOAD_CYC(40), .PROG_CYC(400)) DUT (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_id(cmd_id),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .timeout(timeout), .busy(busy),
    .soft_write_lock(soft_write_lock),
    .byte_address_lines(byte_address_lines), .mem_dout(mem_dout),
    .mem_doe(mem_doe), .mem_din(mem_din), .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .id_area_select_line(id_area_select_line)
  );
  ehc_mem_model u_mem (
    .addr(byte_address_lines), .dq(mem_din), .ce_n(mem_ce_n),
    .oe_n(mem_oe_n), .we_n(mem_we_n), .id_sel(id_area_select_line),
    .q(q), .q_oe(q_oe)
  );
  initial forever #5 clock = ~clock;
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ok(input logic b);
    check({15'h0000, b}, 16'h0001);
  endtask
  task automatic do_reset;
    @(negedge clock);
    rst = 1;
    repeat (12) @(negedge clock);
    rst = 0;
  endtask
  task automatic send(input logic [1:0] op, input logic [14:0] a,
      input logic [7:0] d, input logic id, input logic last);
    int k = 0;
    @(negedge clock);
    cmd_valid = 1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_id = id;
    cmd_last = last;
    while (cmd_ready !== 1'b1 && k < 2000) begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    cmd_valid = 0;
  endtask
  task automatic wait_end;
    dn = 0;
    tm = 0;
    for (cy = 0; cy < 2000 && !dn && !tm; cy++) begin
      @(negedge clock);
      dn = done;
      tm = timeout;
    end
  endtask
  task automatic wr1(input logic [14:0] a, input logic [7:0] d, input logic id);
    send(`EHC_OP_WRITE, a, d, id, 1'b1);
    wait_end();
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic id,
      input logic [7:0] e);
    int k = 0;
    send(`EHC_OP_READ, a, 8'h00, id, 1'b1);
    while (rd_valid !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    check({rd_valid, 7'h00, rd_data}, {1'b1, 7'h00, e});
  endtask
  task automatic t_byte;
    wr1(15'h1234, 8'hA5, 1'b0);
    ok(dn && cy >= 140);
    rd_chk(15'h1234, 1'b0, 8'hA5);
  endtask
  task automatic t_page;
    int p0 = u_mem.n_prog;
    send(`EHC_OP_WRITE, 15'h0143, 8'h11, 1'b0, 1'b0);
    send(`EHC_OP_WRITE, 15'h0140, 8'h22, 1'b0, 1'b0);
    send(`EHC_OP_WRITE, 15'h0143, 8'h33, 1'b0, 1'b0);
    send(`EHC_OP_WRITE, 15'h017F, 8'h44, 1'b0, 1'b0);
    wait_end();
    ok(dn && u_mem.n_prog == p0 + 1);
    rd_chk(15'h0143, 1'b0, 8'h33);
    rd_chk(15'h0140, 1'b0, 8'h22);
    rd_chk(15'h017F, 1'b0, 8'h44);
    rd_chk(15'h0141, 1'b0, 8'hFF);
    // A read during an open load is held until the page is programmed
    send(`EHC_OP_WRITE, 15'h0500, 8'h3E, 1'b0, 1'b0);
    rd_chk(15'h0500, 1'b0, 8'h3E);
  endtask
  task automatic t_id;
    wr1(15'h7FC5, 8'h5C, 1'b1);
    rd_chk(15'h7FC5, 1'b1, 8'h5C);
    rd_chk(15'h7FC5, 1'b0, 8'hFF);
  endtask
  task automatic t_lock;
    send(`EHC_OP_LOCK, 15'h0000, 8'h00, 1'b0, 1'b1);
    wait_end();
    ok(dn && soft_write_lock === 1'b1 && u_mem.lock === 1'b1);
    rd_chk(`EHC_SEQ_ADDR1, 1'b0, 8'hFF);
    wr1(15'h0200, 8'h77, 1'b0);
    rd_chk(15'h0200, 1'b0, 8'h77);
  endtask
  task automatic t_relock;
    do_reset();
    ok(soft_write_lock === 1'b0 && u_mem.lock === 1'b1);
    wr1(15'h0300, 8'h12, 1'b0);
    ok(dn && cy >= 140);
    rd_chk(15'h0300, 1'b0, 8'hFF);
    send(`EHC_OP_UNLOCK, 15'h0000, 8'h00, 1'b0, 1'b1);
    wait_end();
    ok(dn && u_mem.lock === 1'b0);
    wr1(15'h0300, 8'h12, 1'b0);
    rd_chk(15'h0300, 1'b0, 8'h12);
  endtask
  task automatic t_slow;
    u_mem.prog_ns = 6000;
    wr1(15'h0400, 8'h09, 1'b0);
    ok(tm && !dn);
    u_mem.prog_ns = 1500;
    rd_chk(15'h0400, 1'b0, 8'h09);
  endtask
  initial begin
    do_reset();
    t_byte();
    t_page();
    t_id();
    t_lock();
    t_relock();
    t_slow();
    print_verdict();
  end
endmodule
`default_nettype wire
